// ==== include/serial_control_pkg.sv ====
/*
  Register map, field positions, reset values and timing counts for the
  serial control enables block. Assumes an AXI4-Lite slave with 32-bit data.
*/
package serial_control_pkg;
  // Byte addresses
  localparam logic [4:0] ADDR_CONTROL  = 5'h00;
  localparam logic [4:0] ADDR_FORMAT   = 5'h04;
  localparam logic [4:0] ADDR_STATUS   = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_EN   = 5'h10;
  localparam logic [4:0] ADDR_IRQ_CLR  = 5'h14;

  // Control register fields
  localparam int TX_IRQ_ON_BIT      = 7;
  localparam int RX_IRQ_ON_BIT      = 6;
  localparam int TX_ON_BIT          = 5;
  localparam int RX_ON_BIT          = 4;
  localparam int ADDR_WAIT_SKIP_BIT = 3;
  localparam int TX_DONE_IRQ_ON_BIT = 2;
  localparam int CLK_SEL_HI_BIT     = 1;
  localparam int CLK_SEL_LO_BIT     = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Format register fields
  localparam int SYNC_MODE_BIT          = 7;
  localparam int ADDRESS_FRAME_MODE_BIT = 2;
  localparam logic [7:0] FORMAT_RESET   = 8'h00;

  // Status register fields
  localparam int TX_EMPTY_BIT = 7;
  localparam int RX_FULL_BIT  = 6;
  localparam int OVERRUN_BIT  = 5;
  localparam int FRAMING_BIT  = 4;
  localparam int TX_DONE_BIT  = 2;
  localparam logic [7:0] STATUS_RESET = 8'h84;

  // Sticky event bits
  localparam int EV_TX_EMPTY = 0;
  localparam int EV_RX_FULL  = 1;
  localparam int EV_RX_ERROR = 2;
  localparam int EV_TX_DONE  = 3;
  localparam int EV_ADDR_HIT = 4;
  localparam int EV_COUNT    = 5;

  // Clock select encodings
  localparam logic [1:0] CLKSEL_INT     = 2'h0;
  localparam logic [1:0] CLKSEL_INT_OUT = 2'h1;
  localparam logic [1:0] CLKSEL_EXT     = 2'h2;

  // Oversampling of the external asynchronous clock
  localparam int EXT_OVERSAMPLE = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/edge_pulse.sv ====
/*
  Rising-edge detector producing a one-cycle pulse.
  Assumes the input is already synchronous to aclk.
*/
`timescale 1ns/1ps
module edge_pulse
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Level in, pulse out
  input  wire logic level,
  output logic      pulse
);
  logic level_q;

  always_ff @(posedge aclk)
  begin
    // Starts high so an idle-high clock line gives no false edge after reset
    if (!aresetn)
      level_q <= 1'b1;
    else
      level_q <= level;
  end

  assign pulse = level & ~level_q;
endmodule

// ==== design/rate_divider.sv ====
/*
  Divider giving a one-cycle enable on every DIV-th cycle in which run is high.
  Assumes a single clock; reset restarts the count, a low run only pauses it.
*/
`timescale 1ns/1ps
module rate_divider
#(
  parameter int DIV = 16
)
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic run,
  output logic      tick
);
  logic [15:0] count_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= 16'h0000;
    else if (run)
    begin
      if (count_q == 16'(DIV - 1))
        count_q <= 16'h0000;
      else
        count_q <= count_q + 16'h0001;
    end
  end

  assign tick = run && (count_q == 16'(DIV - 1));
endmodule

// ==== design/serial_control_enables.sv ====
/*
  Control register logic of a serial communication unit: interrupt gating,
  transmit/receive enables, address-wait filtering and serial clock pin
  selection. Assumes the shifters and baud generator outside supply event
  pulses and a bit-rate tick; registers reached over AXI4-Lite.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
// Behaviour
// - tx_irq_on gates the transmit-empty interrupt request.
// - rx_irq_on gates both receive-full and receive-error requests.
// - Transmission runs only while tx_on is set.
// - Reception runs only while rx_on is set.
// - addr_wait_skip acts only in asynchronous mode with address frames.
// - While waiting, frames with address bit 0 set no receive flags.
// - An address-bit-1 frame clears addr_wait_skip and resumes reception.
// - tx_done_irq_on gates the transmit-end interrupt request.
// - Async 00/01 use internal generator; 01 drives bit-rate clock out.
// - Async 10 takes pin clock at sixteen times bit rate.
// - Synchronous 00 generates the clock and drives it on the pin.
// - Synchronous 10 makes the pin an input fed by the far party.
// - Format mode bit: 0 asynchronous, 1 clocked synchronous.
// - With tx_on clear, transmit-empty and transmit-end flags stay set.
`timescale 1ns/1ps
module serial_control_enables
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Events from the shifters
  input  wire logic        tx_loaded,
  input  wire logic        tx_written,
  input  wire logic        tx_last_bit,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_frame_mpb,
  input  wire logic        rx_framing_err,
  input  wire logic        rx_overrun,
  input  wire logic        bit_rate_tick,
  // Enables to the shifters
  output logic             tx_run,
  output logic             rx_run,
  output logic             ext_clk_tick,
  // Serial clock pin
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  // Interrupts
  output logic             tx_empty_irq,
  output logic             rx_full_irq,
  output logic             rx_error_irq,
  output logic             tx_done_irq,
  output logic             irq
);
  logic [7:0]  control_q;
  logic [7:0]  format_q;
  logic [7:0]  flags_q;
  logic [serial_control_pkg::EV_COUNT-1:0] ev_stat_q;
  logic [serial_control_pkg::EV_COUNT-1:0] ev_en_q;
  logic [serial_control_pkg::EV_COUNT-1:0] ev_set;
  logic [serial_control_pkg::EV_COUNT-1:0] ev_clr;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [4:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic        wr_fire;
  logic        wr_ok;
  logic        rd_fire;
  logic        sync_mode;
  logic        waiting;
  logic        frame_accept;
  logic        pin_edge;
  logic        ext_div_tick;
  logic        ctrl_wr;
  logic        bit_clk_q;
  logic [1:0]  clk_sel;

  assign sync_mode = format_q[serial_control_pkg::SYNC_MODE_BIT];
  assign clk_sel   = {control_q[serial_control_pkg::CLK_SEL_HI_BIT],
                      control_q[serial_control_pkg::CLK_SEL_LO_BIT]};
  assign waiting   = control_q[serial_control_pkg::ADDR_WAIT_SKIP_BIT] && !sync_mode
                     && format_q[serial_control_pkg::ADDRESS_FRAME_MODE_BIT];
  assign frame_accept = rx_frame_done && rx_run && (!waiting || rx_frame_mpb);

  // Write channel: address and data taken in either order
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_ok   = (awaddr_q == serial_control_pkg::ADDR_CONTROL) || (awaddr_q == serial_control_pkg::ADDR_FORMAT)
                   || (awaddr_q == serial_control_pkg::ADDR_IRQ_EN) || (awaddr_q == serial_control_pkg::ADDR_IRQ_CLR);
  assign ctrl_wr = wr_fire && wstrb0_q && (awaddr_q == serial_control_pkg::ADDR_CONTROL);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      awaddr_q      <= 5'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_q && s_axi_awvalid && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[4:2], 2'h0};
      end
      else if (wr_fire)
        aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold_q     <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb0_q     <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_hold_q && s_axi_wvalid && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= serial_control_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? serial_control_pkg::RESP_OKAY : serial_control_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control register; hardware clear of the wait bit beats a software write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      control_q <= serial_control_pkg::CONTROL_RESET;
    else
    begin
      if (ctrl_wr)
        control_q <= wdata_q[7:0];
      if (waiting && rx_run && rx_frame_done && rx_frame_mpb)
        control_q[serial_control_pkg::ADDR_WAIT_SKIP_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      format_q <= serial_control_pkg::FORMAT_RESET;
    else if (wr_fire && wstrb0_q && awaddr_q == serial_control_pkg::ADDR_FORMAT)
      format_q <= wdata_q[7:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ev_en_q <= '0;
    else if (wr_fire && wstrb0_q && awaddr_q == serial_control_pkg::ADDR_IRQ_EN)
      ev_en_q <= wdata_q[serial_control_pkg::EV_COUNT-1:0];
  end

  // Status flags; setting events win over clearing ones
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_q <= serial_control_pkg::STATUS_RESET;
    else
    begin
      if (tx_written)
      begin
        flags_q[serial_control_pkg::TX_EMPTY_BIT] <= 1'b0;
        flags_q[serial_control_pkg::TX_DONE_BIT]  <= 1'b0;
      end
      if (tx_loaded)
        flags_q[serial_control_pkg::TX_EMPTY_BIT] <= 1'b1;
      if (tx_last_bit && flags_q[serial_control_pkg::TX_EMPTY_BIT])
        flags_q[serial_control_pkg::TX_DONE_BIT] <= 1'b1;
      if (!tx_run)
      begin
        flags_q[serial_control_pkg::TX_EMPTY_BIT] <= 1'b1;
        flags_q[serial_control_pkg::TX_DONE_BIT]  <= 1'b1;
      end
      if (frame_accept)
      begin
        flags_q[serial_control_pkg::RX_FULL_BIT] <= !rx_framing_err;
        flags_q[serial_control_pkg::FRAMING_BIT] <= rx_framing_err;
        if (rx_overrun)
          flags_q[serial_control_pkg::OVERRUN_BIT] <= 1'b1;
      end
      else if (rd_fire && s_axi_araddr[4:2] == serial_control_pkg::ADDR_STATUS[4:2])
      begin
        // Reading the status acknowledges the receive flags
        flags_q[serial_control_pkg::RX_FULL_BIT] <= 1'b0;
        flags_q[serial_control_pkg::FRAMING_BIT] <= 1'b0;
        flags_q[serial_control_pkg::OVERRUN_BIT] <= 1'b0;
      end
    end
  end

  assign tx_run = control_q[serial_control_pkg::TX_ON_BIT];
  assign rx_run = control_q[serial_control_pkg::RX_ON_BIT];

  // Sticky events, write-one-to-clear, set wins
  assign ev_set[serial_control_pkg::EV_TX_EMPTY] = tx_loaded;
  assign ev_set[serial_control_pkg::EV_RX_FULL]  = frame_accept && !rx_framing_err;
  assign ev_set[serial_control_pkg::EV_RX_ERROR] = frame_accept && (rx_framing_err || rx_overrun);
  assign ev_set[serial_control_pkg::EV_TX_DONE]  = tx_last_bit && flags_q[serial_control_pkg::TX_EMPTY_BIT];
  assign ev_set[serial_control_pkg::EV_ADDR_HIT] = waiting && rx_run && rx_frame_done && rx_frame_mpb;
  assign ev_clr = (wr_fire && wstrb0_q && awaddr_q == serial_control_pkg::ADDR_IRQ_CLR)
                  ? wdata_q[serial_control_pkg::EV_COUNT-1:0] : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ev_stat_q <= '0;
    else
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
  end

  // Request lines: status AND enable, registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_empty_irq <= 1'b0;
      rx_full_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_done_irq  <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      tx_empty_irq <= flags_q[serial_control_pkg::TX_EMPTY_BIT] && control_q[serial_control_pkg::TX_IRQ_ON_BIT];
      rx_full_irq  <= flags_q[serial_control_pkg::RX_FULL_BIT] && control_q[serial_control_pkg::RX_IRQ_ON_BIT];
      rx_error_irq <= (flags_q[serial_control_pkg::FRAMING_BIT] || flags_q[serial_control_pkg::OVERRUN_BIT])
                      && control_q[serial_control_pkg::RX_IRQ_ON_BIT];
      tx_done_irq  <= flags_q[serial_control_pkg::TX_DONE_BIT] && control_q[serial_control_pkg::TX_DONE_IRQ_ON_BIT];
      irq          <= |(ev_stat_q & ev_en_q);
    end
  end

  // Serial clock pin; reserved encodings leave the pin undriven
  edge_pulse u_pin_edge
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (serial_clock_pin_i),
    .pulse   (pin_edge)
  );

  rate_divider #(.DIV(serial_control_pkg::EXT_OVERSAMPLE)) u_ext_div
  (
    .aclk    (aclk),
    .aresetn (aresetn && !sync_mode && (clk_sel == serial_control_pkg::CLKSEL_EXT)),
    .run     (pin_edge),
    .tick    (ext_div_tick)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bit_clk_q           <= 1'b1;
      serial_clock_pin_o  <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
      ext_clk_tick        <= 1'b0;
    end
    else
    begin
      if (bit_rate_tick)
        bit_clk_q <= ~bit_clk_q;
      serial_clock_pin_o  <= bit_clk_q;
      serial_clock_pin_oe <= sync_mode ? (clk_sel == serial_control_pkg::CLKSEL_INT)
                                       : (clk_sel == serial_control_pkg::CLKSEL_INT_OUT);
      // Async: one tick per sixteen pin edges, a bit time; sync: one per edge
      ext_clk_tick <= (clk_sel == serial_control_pkg::CLKSEL_EXT) && (sync_mode ? pin_edge : ext_div_tick);
    end
  end

  // Read channel
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= serial_control_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && s_axi_arvalid && !s_axi_arready;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= serial_control_pkg::RESP_OKAY;
        unique case ({s_axi_araddr[4:2], 2'h0})
          serial_control_pkg::ADDR_CONTROL:  s_axi_rdata <= {24'h000000, control_q};
          serial_control_pkg::ADDR_FORMAT:   s_axi_rdata <= {24'h000000, format_q};
          serial_control_pkg::ADDR_STATUS:   s_axi_rdata <= {24'h000000, flags_q};
          serial_control_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {27'h0000000, ev_stat_q};
          serial_control_pkg::ADDR_IRQ_EN:   s_axi_rdata <= {27'h0000000, ev_en_q};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= (s_axi_araddr[4:2] == serial_control_pkg::ADDR_IRQ_CLR[4:2])
                           ? serial_control_pkg::RESP_OKAY : serial_control_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== bench/serial_control_assertions.sv ====
/*
  Port assertions for serial_control_enables.
  Assumes one write at a time, bready held high and full-word writes.
*/
`timescale 1ns/1ps
module serial_control_assertions
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic [4:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Shifter side and pin
  input wire logic        bit_rate_tick,
  input wire logic        tx_run,
  input wire logic        rx_run,
  input wire logic        ext_clk_tick,
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe,
  // Interrupts
  input wire logic        tx_empty_irq,
  input wire logic        rx_full_irq,
  input wire logic        rx_error_irq,
  input wire logic        tx_done_irq,
  input wire logic        irq
);
  logic [4:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] ctl_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      addr_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      data_q <= s_axi_wdata[7:0];
  end

  // Shadow commits with the response, the cycle the enables take effect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctl_q <= 8'h00;
    else if (s_axi_bvalid && s_axi_bready && addr_q == serial_control_pkg::ADDR_CONTROL)
      ctl_q <= data_q;
  end

  reset_quiet_a : assert property (disable iff (1'b0) !aresetn |=>
    !tx_run && !rx_run && !serial_clock_pin_oe && !irq && !tx_empty_irq && !rx_full_irq && !tx_done_irq)
    else $error("output active after reset");
  tx_irq_gate_a : assert property (tx_empty_irq |-> ctl_q[7])
    else $error("transmit request while disabled");
  rx_irq_gate_a : assert property (rx_full_irq || rx_error_irq |-> ctl_q[6])
    else $error("receive request while disabled");
  done_irq_gate_a : assert property (tx_done_irq |-> ctl_q[2])
    else $error("transmit end request while disabled");
  pin_paced_a : assert property ($past(serial_clock_pin_oe) && serial_clock_pin_oe &&
    $changed(serial_clock_pin_o) |-> $past(bit_rate_tick, 2)) else $error("pin clock moved without tick");
  pin_toggle_a : assert property (serial_clock_pin_oe && bit_rate_tick ##1 serial_clock_pin_oe
    |=> serial_clock_pin_o != $past(serial_clock_pin_o)) else $error("pin clock missed a tick");
  tick_input_only_a : assert property (ext_clk_tick |-> !serial_clock_pin_oe)
    else $error("external tick while driving pin");
  tick_pulse_a : assert property (ext_clk_tick |=> !ext_clk_tick)
    else $error("external tick longer than one cycle");
endmodule

bind serial_control_enables serial_control_assertions chk (.*);

// ==== bench/remote_node.sv ====
/*
  Remote node on the serial clock pin: supplies a clock on request and
  counts rising edges of the clock the device drives. Single aclk domain.
*/
`timescale 1ns/1ps
module remote_node
(
  // Clock
  input  wire logic aclk,
  // Device pin drive
  input  wire logic dev_o,
  input  wire logic dev_oe,
  // Bench control
  input  wire logic drive,
  input  wire logic run,
  // Line and edge counts
  output logic      line,
  output int        sent,
  output int        seen
);
  logic [2:0] div_q = 3'h0;
  logic       clk_q = 1'b0;
  logic       flt_q = 1'b0;
  logic       last_q = 1'b0;

  initial sent = 0;
  initial seen = 0;
  // A released pin toggles so a stale level never passes for a driven one
  assign line = dev_oe ? dev_o : (drive ? clk_q : flt_q);
  // The external clock stands still unless a burst is running
  always @(posedge aclk)
  begin
    div_q  <= div_q + 3'h1;
    flt_q  <= ~flt_q;
    last_q <= line;
    if (run && div_q == 3'h7)
      clk_q <= ~clk_q;
    if (run && div_q == 3'h7 && !clk_q)
      sent <= sent + 1;
    if (dev_oe && line && !last_q)
      seen <= seen + 1;
  end
endmodule

// ==== bench/test_serial_control_enables.sv ====
/*
  Bench for serial_control_enables: a table of control settings, then pin
  clock, address wait, flags and events, unmapped and reset cases.
  Assumes remote_node on the pin and the bound checker.
*/
`timescale 1ns/1ps
module test_serial_control_enables;
  logic        aclk = 1'b0, aresetn = 1'b0, drive = 1'b0, run = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1, tx_loaded = 1'b0, tx_written = 1'b0, tx_last_bit = 1'b0;
  logic        rx_frame_done = 1'b0, rx_frame_mpb = 1'b0, rx_framing_err = 1'b0, rx_overrun = 1'b0;
  logic        bit_rate_tick = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs_q;
  logic        tx_run, rx_run, ext_clk_tick, serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe;
  logic        tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq, irq;
  int          sent, seen, k, j, nticks = 0, n_fail = 0, cmp_count = 0;
  // Control, format, then {tx_run, rx_run, pin_oe, tx_empty, rx_full, rx_error, tx_done}
  // Reserved select codes are never programmed
  logic [22:0] rows [10] = '{{8'h80, 8'h00, 7'h08}, {8'h04, 8'h00, 7'h01}, {8'hC4, 8'h00, 7'h09},
    {8'h20, 8'h00, 7'h40}, {8'h10, 8'h00, 7'h20}, {8'h01, 8'h00, 7'h10}, {8'h00, 8'h80, 7'h10},
    {8'h02, 8'h80, 7'h00}, {8'h02, 8'h00, 7'h00}, {8'h00, 8'h00, 7'h00}};

  serial_control_enables uut (.*);
  remote_node peer (.aclk(aclk), .dev_o(serial_clock_pin_o), .dev_oe(serial_clock_pin_oe), .drive(drive),
    .run(run), .line(serial_clock_pin_i), .sent(sent), .seen(seen));

  always #5 aclk = ~aclk;
  always @(posedge aclk) bit_rate_tick <= ~bit_rate_tick;
  always @(posedge aclk) if (ext_clk_tick === 1'b1) nticks <= nticks + 1;

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Each valid drops at the edge its ready is seen; waits end on the answer
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (w)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
    end
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 60);
    rs_q = w ? s_axi_bresp : s_axi_rresp;
    rd_q = s_axi_rdata;
    if (n == 60)
    begin
      n_fail++;
      results;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic ctl(input logic [7:0] d);
    bus(1'b1, serial_control_pkg::ADDR_CONTROL, 32'(d));
  endtask

  task automatic frame(input logic mpb, input logic err);
    rx_frame_mpb <= mpb;
    rx_framing_err <= err;
    rx_overrun <= err;
    rx_frame_done <= 1'b1;
    @(posedge aclk);
    rx_frame_done <= 1'b0;
    cyc(3);
  endtask

  initial
  begin
    cyc(10);
    aresetn <= 1'b1;
    // Control before format, so no reserved select shows in between
    for (int i = 0; i < 10; i++)
    begin
      ctl(rows[i][22:15]);
      wr(serial_control_pkg::ADDR_FORMAT, 32'(rows[i][14:7]));
      cyc(3);
      chk(32'({tx_run, rx_run, serial_clock_pin_oe, tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq}),
        32'(rows[i][6:0]));
      rd(serial_control_pkg::ADDR_CONTROL);
      chk(rd_q, 32'(rows[i][22:15]));
    end
    $display("table done");
    ctl(8'h01);
    k = seen;
    cyc(40);
    chk(32'(seen - k > 8), 32'h1);
    drive <= 1'b1;
    ctl(8'h00);
    // Async external first: sixteen pin edges per tick; then synchronous: one per edge
    for (int m = 0; m < 2; m++)
    begin
      ctl(8'h02);
      k = nticks;
      j = sent;
      run <= 1'b1;
      cyc(600);
      run <= 1'b0;
      cyc(8);
      chk(32'(nticks - k), 32'(m ? sent - j : (sent - j) / serial_control_pkg::EXT_OVERSAMPLE));
      wr(serial_control_pkg::ADDR_FORMAT, 32'h80);
    end
    ctl(8'h00);
    drive <= 1'b0;
    $display("pin clock done");
    wr(serial_control_pkg::ADDR_FORMAT, 32'h04);
    ctl(8'h58);
    frame(1'b0, 1'b1);
    chk(32'({rx_full_irq, rx_error_irq}), 32'h0);
    rd(serial_control_pkg::ADDR_STATUS);
    chk(32'(rd_q[6:4]), 32'h0);
    frame(1'b1, 1'b0);
    chk(32'(rx_full_irq), 32'h1);
    rd(serial_control_pkg::ADDR_CONTROL);
    chk(rd_q, 32'h50);
    ctl(8'h18);
    cyc(2);
    chk(32'(rx_full_irq), 32'h0);
    rd(serial_control_pkg::ADDR_STATUS);
    wr(serial_control_pkg::ADDR_FORMAT, 32'h00);
    ctl(8'h58);
    frame(1'b0, 1'b1);
    chk(32'({rx_full_irq, rx_error_irq}), 32'h1);
    rd(serial_control_pkg::ADDR_STATUS);
    ctl(8'h40);
    frame(1'b1, 1'b1);
    chk(32'({rx_full_irq, rx_error_irq}), 32'h0);
    $display("address wait done");
    ctl(8'h20);
    wr(serial_control_pkg::ADDR_IRQ_CLR, 32'h1F);
    wr(serial_control_pkg::ADDR_IRQ_EN, 32'h01);
    tx_written <= 1'b1;
    @(posedge aclk);
    tx_written <= 1'b0;
    cyc(2);
    rd(serial_control_pkg::ADDR_STATUS);
    chk(rd_q & 32'h84, 32'h0);
    tx_loaded <= 1'b1;
    @(posedge aclk);
    tx_loaded <= 1'b0;
    tx_last_bit <= 1'b1;
    @(posedge aclk);
    tx_last_bit <= 1'b0;
    cyc(3);
    chk(32'(irq), 32'h1);
    rd(serial_control_pkg::ADDR_IRQ_STAT);
    chk(rd_q & 32'h9, 32'h9);
    wr(serial_control_pkg::ADDR_IRQ_EN, 32'h00);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(serial_control_pkg::ADDR_IRQ_CLR, 32'h01);
    rd(serial_control_pkg::ADDR_IRQ_STAT);
    chk(rd_q & 32'h1, 32'h0);
    ctl(8'h00);
    rd(serial_control_pkg::ADDR_STATUS);
    chk(rd_q & 32'h84, 32'h84);
    $display("flags and events done");
    wr(5'h18, 32'h1);
    chk(32'(rs_q), 32'(serial_control_pkg::RESP_SLVERR));
    rd(5'h1C);
    chk(32'(rs_q), 32'(serial_control_pkg::RESP_SLVERR));
    $display("unmapped done");
    s_axi_wstrb <= 4'h0;
    ctl(8'hFF);
    s_axi_wstrb <= 4'hF;
    rd(serial_control_pkg::ADDR_CONTROL);
    chk(rd_q, 32'h0);
    ctl(8'hF5);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    rd(serial_control_pkg::ADDR_CONTROL);
    chk(rd_q, 32'h0);
    rd(serial_control_pkg::ADDR_STATUS);
    chk(rd_q, 32'h84);
    chk(32'({tx_run, rx_run, serial_clock_pin_oe, irq}), 32'h0);
    $display("reset done");
    results;
  end
endmodule
